// ===== core/tws_dev.sv
/*
  Slave end of the two-wire link: detects start and stop, receives the
  address byte, register address and write data, returns read data and
  drives the acknowledge slots.
  Assumes the serial lines are asynchronous to core_clk and that the
  serial clock is slow enough for several core cycles per level.
*/
// Operation
// [RL1] Address byte: bits 7..1 address, bit0 direction
// [RL2] Select low answers 0x90 write, 0x91 read
// [RL3] Select high answers 0xBA write, 0xBB read
// [RL4] Later bytes: register address, write/read data
// [RL5] Acknowledge slot follows every byte
// [RL6] Transmitter releases data during acknowledge slot
// [RL7] Receiver pulls data low to acknowledge
// [RL8] Data changes only while clock low
// [RL9] Released high line after byte means no-acknowledge
// [RL10] Master no-acknowledge ends read; device releases line
// [RL11] Start: data falls while clock high
// [RL12] Stop: data rises while clock high; release
// [RL13] Bytes shift most significant bit first
// [RL14] Sixteen-bit address then data, high byte first
// [RL15] Address mismatch: stay released until next start
`timescale 1ns/1ps
module tws_dev
  import tws_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        addr_select_pin,
  tws_if.dev               bus,
  input  wire logic [15:0] rd_data,
  output logic      [15:0] reg_addr,
  output logic      [15:0] wr_addr,
  output logic      [15:0] wr_data,
  output logic             wr_stb
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Matches the seven address bits against the selected pair.
  function automatic logic addr_hit(input logic [7:0] b, input logic sel);
    logic [7:0] own;
    own = sel ? TWS_ADDR_WR_ALT : TWS_ADDR_WR_DEF;
    addr_hit = (b[7:1] == own[7:1]);
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic scl_s1;
  logic scl_s2;
  logic scl_s3;
  logic sda_s1;
  logic sda_s2;
  logic sda_s3;
  logic sel_s1;
  logic sel_s2;

  // Two flops per pin; the third flop only keeps history for edges.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {sel_s1, sel_s2}         <= 2'h0;
    end else if (clk_en) begin
      {scl_s1, scl_s2, scl_s3} <= {bus.scl_line, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {bus.sda_line, sda_s1, sda_s2};
      {sel_s1, sel_s2}         <= {addr_select_pin, sel_s1};
    end
  end

  // Line events seen on the synchronised samples.
  logic scl_rise;
  logic scl_fall;
  logic got_start;
  logic got_stop;

  assign scl_rise  = scl_s2 & ~scl_s3;
  assign scl_fall  = ~scl_s2 & scl_s3;
  assign got_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;  // RL11
  assign got_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;  // RL12

  // ----------------------------------------------------------------------
  // Framing state
  // ----------------------------------------------------------------------
  tws_dev_st_t st;
  tws_dev_st_t next_st;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [7:0]  sh;
  logic [7:0]  next_sh;
  logic [1:0]  byte_idx;
  logic [1:0]  next_byte_idx;
  logic        is_read;
  logic        next_is_read;
  logic        mack;
  logic        next_mack;
  logic        tx_half;
  logic        next_tx_half;
  logic [7:0]  rd_lo;
  logic [7:0]  next_rd_lo;
  logic [15:0] next_reg_addr;
  logic [15:0] next_wr_addr;
  logic [15:0] next_wr_data;
  logic        next_wr_stb;
  logic        next_sda_oe;

  // Next read byte: high half comes live from rd_data, low half from
  // the copy taken with it, so both halves belong to one register.
  logic [7:0] tx_byte;
  assign tx_byte = tx_half ? rd_lo : rd_data[15:8];  // RL14

  // Next-value logic for the whole framing engine.
  always_comb begin
    next_st       = st;
    next_bit_cnt  = bit_cnt;
    next_sh       = sh;
    next_byte_idx = byte_idx;
    next_is_read  = is_read;
    next_mack     = mack;
    next_tx_half  = tx_half;
    next_rd_lo    = rd_lo;
    next_reg_addr = reg_addr;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    next_wr_stb   = 1'b0;
    next_sda_oe   = bus.dev_sda_oe;
    if (got_start) begin
      // A start, repeated or not, always wins over the byte in flight.
      next_st       = TWS_D_ADDR;  // RL11
      next_bit_cnt  = '0;
      next_byte_idx = TWS_IDX_AHI;
      next_tx_half  = 1'b0;
      next_sda_oe   = 1'b0;
    end else if (got_stop) begin
      next_st     = TWS_D_IDLE;  // RL12
      next_sda_oe = 1'b0;  // RL12
    end else begin
      unique case (st)
        TWS_D_IDLE: begin
          next_sda_oe = 1'b0;  // RL15
        end
        TWS_D_ADDR, TWS_D_RX: begin
          if (scl_rise) begin
            next_sh      = {sh[6:0], sda_s2};  // RL13
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == TWS_BYTE_BITS) begin
            next_bit_cnt = '0;
            next_st      = TWS_D_ACK;  // RL5
            next_sda_oe  = 1'b1;  // RL7 RL8
            if (st == TWS_D_ADDR) begin
              next_is_read = sh[TWS_DIR_BIT];  // RL1
              if (!addr_hit(sh, sel_s2)) begin  // RL2 RL3
                next_st     = TWS_D_IDLE;  // RL15
                next_sda_oe = 1'b0;  // RL15
              end
            end else begin
              unique case (byte_idx)  // RL4 RL14
                TWS_IDX_AHI: next_reg_addr = {sh, reg_addr[7:0]};
                TWS_IDX_ALO: next_reg_addr = {reg_addr[15:8], sh};
                TWS_IDX_DHI: next_wr_data  = {sh, wr_data[7:0]};
                TWS_IDX_DLO: begin
                  next_wr_data  = {wr_data[15:8], sh};
                  next_wr_stb   = 1'b1;
                  next_wr_addr  = reg_addr;
                  next_reg_addr = reg_addr + TWS_PTR_STEP;
                end
              endcase
              next_byte_idx = (byte_idx == TWS_IDX_DLO) ? TWS_IDX_DHI
                                                         : byte_idx + 2'h1;
            end
          end
        end
        TWS_D_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_st     = TWS_D_RX;
            if (is_read) begin
              // The first read bit goes out on the same falling edge.
              next_sh      = tx_byte;
              next_sda_oe  = ~tx_byte[7];  // RL8 RL13
              next_st      = TWS_D_TX;
              next_tx_half = ~tx_half;
              if (!tx_half) begin
                next_rd_lo = rd_data[7:0];
              end else begin
                next_reg_addr = reg_addr + TWS_PTR_STEP;
              end
            end
          end
        end
        TWS_D_TX: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == TWS_BYTE_BITS) begin
              next_bit_cnt = '0;
              next_sda_oe  = 1'b0;  // RL6
              next_st      = TWS_D_MACK;  // RL5
            end else begin
              next_sh     = {sh[6:0], 1'b0};
              next_sda_oe = ~sh[6];  // RL8 RL13
            end
          end
        end
        TWS_D_MACK: begin
          if (scl_rise) begin
            next_mack = ~sda_s2;  // RL7 RL9
          end else if (scl_fall) begin
            if (mack) begin
              next_sh      = tx_byte;
              next_sda_oe  = ~tx_byte[7];  // RL8
              next_st      = TWS_D_TX;
              next_tx_half = ~tx_half;
              if (!tx_half) begin
                next_rd_lo = rd_data[7:0];
              end else begin
                next_reg_addr = reg_addr + TWS_PTR_STEP;
              end
            end else begin
              next_st     = TWS_D_IDLE;  // RL10
              next_sda_oe = 1'b0;  // RL10
            end
          end
        end
      endcase
    end
  end

  // Register stage; a low clk_en freezes every flop.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st               <= TWS_D_IDLE;
      bit_cnt          <= '0;
      sh               <= '0;
      byte_idx         <= TWS_IDX_AHI;
      is_read          <= 1'b0;
      mack             <= 1'b0;
      tx_half          <= 1'b0;
      rd_lo            <= '0;
      reg_addr         <= '0;
      wr_addr          <= '0;
      wr_data          <= '0;
      wr_stb           <= 1'b0;
      bus.dev_sda_oe   <= 1'b0;
      bus.dev_sda_out  <= 1'b0;
    end else if (clk_en) begin
      st               <= next_st;
      bit_cnt          <= next_bit_cnt;
      sh               <= next_sh;
      byte_idx         <= next_byte_idx;
      is_read          <= next_is_read;
      mack             <= next_mack;
      tx_half          <= next_tx_half;
      rd_lo            <= next_rd_lo;
      reg_addr         <= next_reg_addr;
      wr_addr          <= next_wr_addr;
      wr_data          <= next_wr_data;
      wr_stb           <= next_wr_stb;
      bus.dev_sda_oe   <= next_sda_oe;
      bus.dev_sda_out  <= 1'b0;  // Open drain: only ever pulls low.
    end
  end

endmodule

// ===== core/tws_pkg.sv
/*
  Shared constants and types for both ends of the two-wire slave link:
  slave addresses, byte framing counts, master clock timing and states.
  Assumes a 100 MHz core clock on both ends.
*/
package tws_pkg;

  // ----------------------------------------------------------------------
  // Addressing and framing
  // ----------------------------------------------------------------------
  localparam logic [7:0] TWS_ADDR_WR_DEF = 8'h90;  // Write, select low.
  localparam logic [7:0] TWS_ADDR_RD_DEF = 8'h91;  // Read, select low.
  localparam logic [7:0] TWS_ADDR_WR_ALT = 8'hBA;  // Write, select high.
  localparam logic [7:0] TWS_ADDR_RD_ALT = 8'hBB;  // Read, select high.
  localparam int         TWS_DIR_BIT     = 0;      // Direction bit.
  localparam logic [3:0] TWS_BYTE_BITS   = 4'h8;   // Bits per byte.
  localparam logic [15:0] TWS_PTR_STEP   = 16'h0001;
  localparam logic [1:0] TWS_IDX_AHI     = 2'h0;   // Register address high.
  localparam logic [1:0] TWS_IDX_ALO     = 2'h1;   // Register address low.
  localparam logic [1:0] TWS_IDX_DHI     = 2'h2;   // Write data high.
  localparam logic [1:0] TWS_IDX_DLO     = 2'h3;   // Write data low.

  // ----------------------------------------------------------------------
  // Timing of the master's serial clock
  // ----------------------------------------------------------------------
  localparam int TWS_CLK_PERIOD_NS = 10;
  localparam int TWS_SCL_PERIOD_NS = 2560;
  // Quarter of a serial clock period in core cycles, rounded down.
  localparam int TWS_QTR_CYC = TWS_SCL_PERIOD_NS / (4 * TWS_CLK_PERIOD_NS);
  localparam logic [7:0] TWS_QTR_LAST = 8'(TWS_QTR_CYC - 1);
  localparam logic [1:0] TWS_PH_LAST  = 2'h3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TWS_D_IDLE, TWS_D_ADDR, TWS_D_RX, TWS_D_ACK, TWS_D_TX, TWS_D_MACK
  } tws_dev_st_t;

  typedef enum logic [1:0] {
    TWS_H_IDLE, TWS_H_START, TWS_H_BIT, TWS_H_STOP
  } tws_host_st_t;

  typedef enum logic [1:0] {
    TWS_OP_START, TWS_OP_STOP, TWS_OP_WRITE, TWS_OP_READ
  } tws_op_t;

endpackage

// ===== core/tws_if.sv
/*
  Two-wire link between the host master and the slave device.
  The master drives the serial clock push-pull; the data line is open
  drain, pulled high when no party pulls it low.
*/
`timescale 1ns/1ps
interface tws_if;

  // ----------------------------------------------------------------------
  // Drivers and resolved lines
  // ----------------------------------------------------------------------
  logic scl_out;
  logic scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl_line;
  logic sda_line;

  // The line is low when any enabled driver drives a zero.
  assign scl_line = scl_oe ? scl_out : 1'b1;
  assign sda_line = ~((host_sda_oe & ~host_sda_out) |
                      (dev_sda_oe & ~dev_sda_out));

  modport host (output scl_out, output scl_oe, output host_sda_out,
                output host_sda_oe, input sda_line);
  modport dev  (output dev_sda_out, output dev_sda_oe,
                input scl_line, input sda_line);

endinterface

// ===== core/tws_host.sv
/*
  Master end of the two-wire link: makes the serial clock from core_clk
  and runs start, stop, byte write and byte read commands one at a time.
  Assumes the slave keeps the slave-side framing rules.
*/
`timescale 1ns/1ps
module tws_host
  import tws_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  tws_if.host             bus,
  input  wire logic       cmd_valid,
  input  wire tws_op_t    cmd_op,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       cmd_ack,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic      [7:0] rsp_byte,
  output logic            rsp_nack
);

  // ----------------------------------------------------------------------
  // Data line synchroniser
  // ----------------------------------------------------------------------
  logic sda_s1;
  logic sda_s2;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {sda_s1, sda_s2} <= 2'h3;
    end else if (clk_en) begin
      {sda_s1, sda_s2} <= {bus.sda_line, sda_s1};
    end
  end

  // ----------------------------------------------------------------------
  // Command engine, four quarter phases per serial clock period
  // ----------------------------------------------------------------------
  tws_host_st_t st;
  tws_host_st_t next_st;
  logic [7:0]   qcnt;
  logic [7:0]   next_qcnt;
  logic [1:0]   ph;
  logic [1:0]   next_ph;
  logic [3:0]   bit_cnt;
  logic [3:0]   next_bit_cnt;
  logic [7:0]   sh;
  logic [7:0]   next_sh;
  logic         rd_mode;
  logic         next_rd_mode;
  logic         ack_bit;
  logic         next_ack_bit;
  logic         next_scl;
  logic         next_sda_oe;
  logic         next_rsp_valid;
  logic [7:0]   next_rsp_byte;
  logic         next_rsp_nack;
  logic         tick;
  logic         drive_low;

  assign tick = (qcnt == TWS_QTR_LAST);
  // Data bits pull low for zeros on write; the ninth bit is our ack on read.
  assign drive_low = (bit_cnt < TWS_BYTE_BITS) ? (~rd_mode & ~sh[7])
                                                : (rd_mode & ack_bit);

  // Next-value logic; the data line changes only while the clock is low, except in the start and stop phases.
  always_comb begin
    next_st        = st;
    next_qcnt      = tick ? '0 : qcnt + 8'h01;
    next_ph        = ph;
    next_bit_cnt   = bit_cnt;
    next_sh        = sh;
    next_rd_mode   = rd_mode;
    next_ack_bit   = ack_bit;
    next_scl       = bus.scl_out;
    next_sda_oe    = bus.host_sda_oe;
    next_rsp_valid = 1'b0;
    next_rsp_byte  = rsp_byte;
    next_rsp_nack  = rsp_nack;
    unique case (st)
      TWS_H_IDLE: begin
        next_qcnt = '0;
        next_ph   = '0;
        if (cmd_valid && cmd_ready) begin
          next_bit_cnt = '0;
          next_sh      = cmd_byte;
          next_rd_mode = (cmd_op == TWS_OP_READ);
          next_ack_bit = cmd_ack;
          unique case (cmd_op)
            TWS_OP_START: next_st = TWS_H_START;
            TWS_OP_STOP:  next_st = TWS_H_STOP;
            TWS_OP_WRITE,
            TWS_OP_READ:  next_st = TWS_H_BIT;
          endcase
        end
      end
      TWS_H_START: begin
        if (tick) begin
          next_ph = ph + 2'h1;
          unique case (ph)
            // The clock keeps its level here: from idle, a low pulse ahead
            // of the start would be a stray bit clock on the bus.
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl    = 1'b1;
            2'h2: next_sda_oe = 1'b1;  // RL11
            2'h3: next_scl    = 1'b0;
          endcase
        end
      end
      TWS_H_STOP: begin
        if (tick) begin
          next_ph = ph + 2'h1;
          unique case (ph)
            2'h0: begin
              next_scl    = 1'b0;
              next_sda_oe = 1'b1;
            end
            2'h1: next_scl    = 1'b1;
            2'h2: next_sda_oe = 1'b0;  // RL12
            2'h3: next_scl    = 1'b1;
          endcase
        end
      end
      TWS_H_BIT: begin
        if (tick) begin
          next_ph = ph + 2'h1;
          unique case (ph)
            2'h0: next_sda_oe = drive_low;  // RL6 RL7 RL8 RL10
            2'h1: next_scl    = 1'b1;
            2'h2: begin
              if (bit_cnt < TWS_BYTE_BITS) begin
                next_sh = {sh[6:0], sda_s2};  // RL13
              end else begin
                next_rsp_nack = sda_s2;  // RL9
              end
            end
            2'h3: begin
              next_scl     = 1'b0;
              next_bit_cnt = bit_cnt + 4'h1;
            end
          endcase
        end
      end
    endcase
    // Every command ends at the close of its last quarter phase.
    if (st != TWS_H_IDLE && tick && ph == TWS_PH_LAST &&
        (st != TWS_H_BIT || bit_cnt == TWS_BYTE_BITS)) begin  // RL5
      next_st        = TWS_H_IDLE;
      next_rsp_valid = 1'b1;
      next_rsp_byte  = sh;
      if (st == TWS_H_BIT) begin
        next_sda_oe = 1'b0;
      end
    end
  end

  // Register stage; a low clk_en freezes every flop.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st               <= TWS_H_IDLE;
      qcnt             <= '0;
      ph               <= '0;
      bit_cnt          <= '0;
      sh               <= '0;
      rd_mode          <= 1'b0;
      ack_bit          <= 1'b0;
      cmd_ready        <= 1'b0;
      rsp_valid        <= 1'b0;
      rsp_byte         <= '0;
      rsp_nack         <= 1'b0;
      bus.scl_out      <= 1'b1;
      bus.scl_oe       <= 1'b0;
      bus.host_sda_oe  <= 1'b0;
      bus.host_sda_out <= 1'b0;
    end else if (clk_en) begin
      st               <= next_st;
      qcnt             <= next_qcnt;
      ph               <= next_ph;
      bit_cnt          <= next_bit_cnt;
      sh               <= next_sh;
      rd_mode          <= next_rd_mode;
      ack_bit          <= next_ack_bit;
      cmd_ready        <= (next_st == TWS_H_IDLE);
      rsp_valid        <= next_rsp_valid;
      rsp_byte         <= next_rsp_byte;
      rsp_nack         <= next_rsp_nack;
      bus.scl_out      <= next_scl;
      bus.scl_oe       <= 1'b1;
      bus.host_sda_oe  <= next_sda_oe;
      bus.host_sda_out <= 1'b0;
    end
  end

endmodule

// ===== tb/tws_link_checker.sv
/*
  Concurrent checks on the resolved two-wire lines between both ends.
  Assumes it sits beside the link and shares the core clock and reset.
*/
`timescale 1ns/1ps
module tws_link_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  // ------------------------------------------------------------------
  // Line history
  // ------------------------------------------------------------------
  logic       scl_q;
  logic       sda_q;
  logic [7:0] lvl_cnt;
  logic [3:0] bit_cnt;
  logic [7:0] next_lvl_cnt;
  logic [3:0] next_bit_cnt;
  logic       start_now;

  // Cycles spent at the present clock level, and clock rises since start or since the last ninth bit.
  always_comb begin
    start_now    = scl_line & scl_q & ~sda_line & sda_q;
    next_lvl_cnt = (scl_line != scl_q) ? 8'h01 :
                   lvl_cnt + {7'h00, lvl_cnt != 8'hFF};
    next_bit_cnt = bit_cnt;
    if (start_now) begin
      next_bit_cnt = 4'h0;
    end else if (scl_line & ~scl_q) begin
      next_bit_cnt = (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
    end
  end

  // Reset to idle levels so release of reset shows no false edge.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      lvl_cnt <= 8'hFF;
      bit_cnt <= 4'h0;
    end else begin
      scl_q   <= scl_line;
      sda_q   <= sda_line;
      lvl_cnt <= next_lvl_cnt;
      bit_cnt <= next_bit_cnt;
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence start_seq;
    scl_line && scl_q && !sda_line && sda_q;
  endsequence
  sequence stop_seq;
    scl_line && scl_q && sda_line && !sda_q;
  endsequence
  sequence ack_rise;
    $rose(dev_sda_oe) && !scl_line;
  endsequence

  chk_dev_low_edge: assert property (
    $changed(dev_sda_oe) |-> !scl_line && lvl_cnt inside {[1:8]})
    else $error("device data drive moved outside the clock low start");
  chk_high_quiet: assert property (
    scl_line && scl_q && sda_line != sda_q |-> $changed(host_sda_oe))
    else $error("data edge under high clock not made by the host");
  chk_ack_holds: assert property (
    ack_rise |-> dev_sda_oe throughout (##[100:300] $fell(scl_line)))
    else $error("device drive dropped before the clock period ended");
  chk_stop_release: assert property (
    stop_seq |-> (!dev_sda_oe)[*8])
    else $error("device drives data after a stop");
  chk_start_quiet: assert property (
    start_seq |-> (!dev_sda_oe)[*8])
    else $error("device drives data right after a start");
  chk_nack_quiet: assert property (
    $rose(scl_line) && bit_cnt == 4'h8 && sda_line |-> (!dev_sda_oe)[*8])
    else $error("device drives data after a no-acknowledge");
  chk_low_phase: assert property (
    $rose(scl_line) |-> lvl_cnt >= 8'h78)
    else $error("serial clock low phase too short");
  chk_high_phase: assert property (
    $fell(scl_line) |-> lvl_cnt >= 8'h78)
    else $error("serial clock high phase too short");
endmodule

// ===== tb/two_wire_slave_byte_framing_tb.sv
/*
  Bench joining host and device ends through the link, driven through the
  host command port, with a register model answering reads.
  Assumes the package constants and the timing of both ends' hand-over.
*/
`timescale 1ns/1ps
module two_wire_slave_byte_framing_tb
  import tws_pkg::*;
;
  logic        core_clk;
  logic        sys_rst;
  logic        clk_en;
  logic        addr_select_pin;
  logic        cmd_valid;
  tws_op_t     cmd_op;
  logic [7:0]  cmd_byte;
  logic        cmd_ack;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_byte;
  logic        rsp_nack;
  logic [15:0] rd_data;
  logic [15:0] reg_addr;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;
  logic        wr_stb;
  logic        scl_d;
  logic [8:0]  wire_sh;
  logic [31:0] stb_log[$];
  int          miscompares;
  int          total_checks;

  tws_if link ();
  tws_host u_tws_host (
    .core_clk (core_clk), .sys_rst (sys_rst), .clk_en (clk_en),
    .bus (link), .cmd_valid (cmd_valid), .cmd_op (cmd_op),
    .cmd_byte (cmd_byte), .cmd_ack (cmd_ack), .cmd_ready (cmd_ready),
    .rsp_valid (rsp_valid), .rsp_byte (rsp_byte), .rsp_nack (rsp_nack)
  );
  tws_dev u_tws_dev (
    .core_clk (core_clk), .sys_rst (sys_rst), .clk_en (clk_en),
    .addr_select_pin (addr_select_pin), .bus (link), .rd_data (rd_data),
    .reg_addr (reg_addr), .wr_addr (wr_addr), .wr_data (wr_data),
    .wr_stb (wr_stb)
  );
  tws_link_checker u_tws_link_checker (
    .core_clk (core_clk), .sys_rst (sys_rst), .scl_line (link.scl_line),
    .sda_line (link.sda_line), .host_sda_oe (link.host_sda_oe),
    .dev_sda_oe (link.dev_sda_oe)
  );

  // Register model: a fixed scramble of the pointer, so each word differs.
  assign rd_data = reg_addr ^ 16'hC35A;

  // The clock toggles every half period of 5 ns.
  always #5 core_clk = ~core_clk;

  // Log write strobes and shift in the line level at each clock rise.
  always @(posedge core_clk) begin
    if (wr_stb === 1'b1) begin
      stb_log.push_back({wr_addr, wr_data});
    end
    if (link.scl_line === 1'b1 && scl_d === 1'b0) begin
      wire_sh = {wire_sh[7:0], link.sda_line};
    end
    scl_d = link.scl_line;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One host command; waits are bounded so a dead end cannot hang here.
  task automatic cmd(input tws_op_t op, input logic [7:0] b,
                     input logic ack);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_byte <= b;
    cmd_ack <= ack;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 3000);
    chk({15'h0000, rsp_valid}, 16'h0001);
  endtask

  task automatic wbyte(input logic [7:0] b, input logic nack);
    cmd(TWS_OP_WRITE, b, 1'b0);
    chk({7'h00, wire_sh}, {7'h00, b, nack});
    chk({7'h00, rsp_byte, rsp_nack}, {7'h00, b, nack});
  endtask

  task automatic rbyte(input logic [7:0] e, input logic ack);
    cmd(TWS_OP_READ, 8'h00, ack);
    chk({8'h00, rsp_byte}, {8'h00, e});
    chk({7'h00, wire_sh}, {7'h00, e, ~ack});
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic run_write(input logic sel, input logic [15:0] a);
    int n0;
    n0 = stb_log.size();
    @(posedge core_clk);
    addr_select_pin <= sel;
    cmd(TWS_OP_START, 8'h00, 1'b0);
    wbyte(sel ? TWS_ADDR_WR_ALT : TWS_ADDR_WR_DEF, 1'b0);
    wbyte(a[15:8], 1'b0);
    wbyte(a[7:0], 1'b0);
    wbyte(~a[15:8], 1'b0);
    wbyte(~a[7:0], 1'b0);
    wbyte(a[7:0], 1'b0);
    wbyte(a[15:8], 1'b0);
    cmd(TWS_OP_STOP, 8'h00, 1'b0);
    chk(16'(stb_log.size() - n0), 16'h0002);
    chk(stb_log[n0][31:16], a);
    chk(stb_log[n0][15:0], ~a);
    chk(stb_log[n0+1][31:16], a + 16'h0001);
    chk(stb_log[n0+1][15:0], {a[7:0], a[15:8]});
  endtask

  // Pointer write, restart, then two read bytes ended by a refusal.
  task automatic run_read(input logic sel, input logic [15:0] a);
    logic [15:0] e;
    e = a ^ 16'hC35A;
    @(posedge core_clk);
    addr_select_pin <= sel;
    cmd(TWS_OP_START, 8'h00, 1'b0);
    wbyte(sel ? TWS_ADDR_WR_ALT : TWS_ADDR_WR_DEF, 1'b0);
    wbyte(a[15:8], 1'b0);
    wbyte(a[7:0], 1'b0);
    cmd(TWS_OP_START, 8'h00, 1'b0);
    wbyte(sel ? TWS_ADDR_RD_ALT : TWS_ADDR_RD_DEF, 1'b0);
    rbyte(e[15:8], 1'b1);
    rbyte(e[7:0], 1'b0);
    repeat (8) @(negedge core_clk);
    chk({15'h0000, link.dev_sda_oe}, 16'h0000);
    cmd(TWS_OP_STOP, 8'h00, 1'b0);
    chk(reg_addr, a + 16'h0001);
  endtask

  // An address of the other pair must be ignored and nothing written.
  task automatic run_foreign(input logic sel);
    int n0;
    n0 = stb_log.size();
    @(posedge core_clk);
    addr_select_pin <= sel;
    cmd(TWS_OP_START, 8'h00, 1'b0);
    wbyte(sel ? TWS_ADDR_WR_DEF : TWS_ADDR_RD_ALT, 1'b1);
    wbyte(8'h3C, 1'b1);
    wbyte(8'h00, 1'b1);
    cmd(TWS_OP_STOP, 8'h00, 1'b0);
    chk(16'(stb_log.size() - n0), 16'h0000);
  endtask

  task automatic final_report();
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    addr_select_pin = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = TWS_OP_START;
    cmd_byte = 8'h00;
    cmd_ack = 1'b0;
    scl_d = 1'b1;
    wire_sh = 9'h000;
    miscompares = 0;
    total_checks = 0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    run_write(1'b0, 16'h12FF);
    run_write(1'b1, 16'hFFFF);
    run_read(1'b0, 16'h12FF);
    run_read(1'b1, 16'h0A5F);
    run_foreign(1'b0);
    run_foreign(1'b1);
    final_report();
  end

  // Watchdog: the scenarios need about 78k cycles, so 95k means a hang.
  initial begin
    #950_000;
    miscompares++;
    final_report();
  end
endmodule
